// *** rwbc_pkg.sv ***
// Package for the reset, wait and backup controller: widths, timing,
// state codes and the display carrier.
// Assumes a 100 MHz reference clock and one system reset input.
//
// Functional notes
// [RULE1] While waiting, the program holds its address until a key line is active, the backup sense pin changes or the half-second flag is set.
// [RULE2] When any release condition occurs, waiting ends and the next address executes.
// [RULE3] A wait issued while a release condition is present acts as a no-operation.
// [RULE4] System reset is entered when the active-low reset pin is low or at power-on.
// [RULE5] After system reset a ten millisecond stand-by runs, then execution starts at address zero.
// [RULE6] During reset and the following stand-by all display commons and segments are driven low.
// [RULE7] System reset places both bidirectional port groups in input mode.
// [RULE8] System reset leaves output and internal port latches unchanged.
// [RULE9] A clock stop with the backup sense pin low halts the clock generator and the CPU while keeping memory.
// [RULE10] In backup mode all display and output port pins are forced low without program action.
// [RULE11] In backup mode each output port keeps its latched value while its pins are low.
// [RULE12] Backup holds the clock stop address; a high backup sense pin ends it and after a ten millisecond stand-by the next address runs.
// [RULE13] A clock stop with the backup sense pin high acts as a no-operation.
// [RULE14] The crystal clock feeds both the clock generator and the reference frequency divider.
// [RULE15] While the backup sense pin is low, the reference divider is held in reset with its output low.
// [RULE16] The stand-by interval is counted in divided clock ticks from a counter cleared at each stand-by start.
package rwbc_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS    = 10;
    localparam int TICK_TIME_NS     = 1000;
    localparam int TICK_CYC         =
        (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STANDBY_TIME_MS  = 10;
    localparam int STANDBY_TICKS_DEF =
        (STANDBY_TIME_MS * 1000000 + TICK_TIME_NS - 1) / TICK_TIME_NS;
    localparam int REF_HALF_TIME_NS = 500000;
    localparam int REF_HALF_TICKS   = REF_HALF_TIME_NS / TICK_TIME_NS;

    // Widths
    localparam int KEY_W  = 4;
    localparam int COM_W  = 2;
    localparam int SEG_W  = 27;
    localparam int OUT_W  = 8;
    localparam int IO_W   = 6;
    localparam int CNT_W  = 24;
    localparam int PRE_W  = 8;
    localparam int REF_W  = 16;
    localparam int PIN_W  = KEY_W + 2;

    // Positions in the synchronised pin vector
    localparam int PIN_RST_POS = PIN_W - 1;
    localparam int PIN_INH_POS = PIN_W - 2;

    // Reset values
    localparam logic [PIN_W-1:0] PIN_RST_VAL  = 6'h20;
    localparam logic [IO_W-1:0]  DIR_INPUT    = 6'h00;
    localparam logic [OUT_W-1:0] OUT_LOW      = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 24'h000000;
    localparam logic [PRE_W-1:0] PRE_ZERO     = 8'h00;
    localparam logic [REF_W-1:0] REF_ZERO     = 16'h0000;

    // Operating states, one-hot
    typedef enum logic [4:0] {
        ST_RESET   = 5'h01,
        ST_STANDBY = 5'h02,
        ST_RUN     = 5'h04,
        ST_WAIT    = 5'h08,
        ST_BACKUP  = 5'h10
    } rwbc_state_e;

    // Display drive group
    typedef struct packed {
        logic [COM_W-1:0] com;
        logic [SEG_W-1:0] seg;
    } rwbc_disp_s;

    localparam rwbc_disp_s DISP_LOW = '{com: 2'h0, seg: 27'h0000000};

endpackage

// *** rwbc_clkgen.sv ***
// Clock generator tick and reference frequency divider.
// Assumes the crystal-rate clock and a synchronised backup sense level.
`timescale 1ns/100ps
module rwbc_clkgen
    import rwbc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic ref_en_i,
    output logic      tick_o,
    output logic      ref_o
);

    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] pre_next;
    logic [PRE_W-1:0] rpre_reg;
    logic [PRE_W-1:0] rpre_next;
    logic [REF_W-1:0] rcnt_reg;
    logic [REF_W-1:0] rcnt_next;
    logic             ref_reg;
    logic             ref_next;
    logic             rtick;

    // Both dividers run from the same crystal clock
    always_comb begin
        pre_next  = pre_reg;
        rpre_next = rpre_reg;
        rcnt_next = rcnt_reg;
        ref_next  = ref_reg;
        tick_o    = 1'b0;
        rtick     = 1'b0;
        if (!run_i) begin
            pre_next = PRE_ZERO; // [RULE9]
        end else if (pre_reg == PRE_W'(TICK_CYC - 1)) begin
            pre_next = PRE_ZERO; // [RULE14]
            tick_o   = 1'b1;
        end else begin
            pre_next = pre_reg + 1'b1;
        end
        if (!ref_en_i) begin
            rpre_next = PRE_ZERO; // [RULE15]
            rcnt_next = REF_ZERO;
            ref_next  = 1'b0;
        end else begin
            if (rpre_reg == PRE_W'(TICK_CYC - 1)) begin
                rpre_next = PRE_ZERO; // [RULE14]
                rtick     = 1'b1;
            end else begin
                rpre_next = rpre_reg + 1'b1;
            end
            if (rtick) begin
                if (rcnt_reg == REF_W'(REF_HALF_TICKS - 1)) begin
                    rcnt_next = REF_ZERO;
                    ref_next  = ~ref_reg;
                end else begin
                    rcnt_next = rcnt_reg + 1'b1;
                end
            end
        end
    end

    // Divider registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_reg  <= PRE_ZERO;
            rpre_reg <= PRE_ZERO;
            rcnt_reg <= REF_ZERO;
            ref_reg  <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            rpre_reg <= rpre_next;
            rcnt_reg <= rcnt_next;
            ref_reg  <= ref_next;
        end
    end

    assign ref_o = ref_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_REF_HELD_LOW: assert property (!ref_en_i |=> !ref_o) // [RULE15]
        else $error("Reference output not low while sense pin low");
    AST_TICK_STOPPED: assert property ( // [RULE9]
        !run_i |=> pre_reg == PRE_ZERO && (!run_i || !tick_o))
        else $error("Clock generator ticked while stopped");

endmodule

// *** rwbc_ctrl.sv ***
// Reset, wait and backup controller for a 4-bit tuning controller core.
// Assumes a CPU sequencer on the same clock issuing one-cycle wait and
// clock-stop strobes, and external reset, backup sense and key pins.
`timescale 1ns/100ps
module rwbc_ctrl
    import rwbc_pkg::*;
#(
    parameter int STANDBY_TICKS = STANDBY_TICKS_DEF
)
(
    input  wire logic             REF_CLK_I,
    input  wire logic             RST_I,
    input  wire logic             RESET_N_PIN_I,
    input  wire logic             BACKUP_SENSE_PIN_I,
    input  wire logic [KEY_W-1:0] KEY_INPUT_LINES_I,
    input  wire logic             HALF_SECOND_TICK_FLAG_I,
    input  wire logic             WAIT_OP_I,
    input  wire logic             CLOCK_STOP_OP_I,
    input  wire logic             OUT_WR_I,
    input  wire logic [OUT_W-1:0] OUT_DATA_I,
    input  wire logic             DIR_WR_I,
    input  wire logic [IO_W-1:0]  DIR_DATA_I,
    input  wire rwbc_disp_s       DISP_I,
    output logic                  CPU_HOLD_O,
    output logic                  NEXT_ADDR_O,
    output logic                  ADDR_ZERO_O,
    output logic                  BACKUP_O,
    output logic                  CLK_GEN_RUN_O,
    output logic                  CPU_TICK_O,
    output logic                  REF_OUT_O,
    output logic [OUT_W-1:0]      OUT_PINS_O,
    output logic [IO_W-1:0]       IO_DIR_O,
    output rwbc_disp_s            DISP_O
);

    // Majority settle of stages two, three and the current value: a bit moves once stages two and three agree
    function automatic logic [PIN_W-1:0] settle(
        input logic [PIN_W-1:0] s2,
        input logic [PIN_W-1:0] s3,
        input logic [PIN_W-1:0] cur
    );
        settle = (s2 & s3) | (cur & (s2 | s3));
    endfunction

    logic [PIN_W-1:0] s1_reg;
    logic [PIN_W-1:0] s2_reg;
    logic [PIN_W-1:0] s3_reg;
    logic [PIN_W-1:0] stb_reg;
    logic [PIN_W-1:0] stb_next;
    logic             inh_prev_reg;
    logic             rst_pin_low;
    logic             inh_level;
    logic             inh_change;
    logic             key_active;
    logic             release_any;

    rwbc_state_e      state_reg;
    rwbc_state_e      state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             from_reset_reg;
    logic             from_reset_next;
    logic             next_addr_reg;
    logic             next_addr_next;
    logic             addr_zero_reg;
    logic             addr_zero_next;
    logic [IO_W-1:0]  dir_reg;
    logic [IO_W-1:0]  dir_next;
    logic [OUT_W-1:0] out_latch_reg;
    logic [OUT_W-1:0] out_latch_next;
    logic [OUT_W-1:0] pins_reg;
    logic [OUT_W-1:0] pins_next;
    rwbc_disp_s       disp_reg;
    rwbc_disp_s       disp_next;
    logic             clk_run;
    logic             tick;
    logic             standby_done;

    // Three-stage synchroniser on all external pins
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s1_reg       <= PIN_RST_VAL;
            s2_reg       <= PIN_RST_VAL;
            s3_reg       <= PIN_RST_VAL;
            stb_reg      <= PIN_RST_VAL;
            inh_prev_reg <= 1'b0;
        end else begin
            s1_reg       <= {RESET_N_PIN_I, BACKUP_SENSE_PIN_I,
                             KEY_INPUT_LINES_I};
            s2_reg       <= s1_reg;
            s3_reg       <= s2_reg;
            stb_reg      <= stb_next;
            inh_prev_reg <= stb_reg[PIN_INH_POS];
        end
    end

    // Settled pin levels and wait release terms
    always_comb begin
        stb_next    = settle(s2_reg, s3_reg, stb_reg);
        rst_pin_low = !stb_reg[PIN_RST_POS];
        inh_level   = stb_reg[PIN_INH_POS];
        inh_change  = inh_level ^ inh_prev_reg;
        key_active  = |stb_reg[KEY_W-1:0];
        release_any = key_active || inh_change
                      || HALF_SECOND_TICK_FLAG_I; // [RULE1]
    end

    // Clock generator and reference divider share the crystal clock
    rwbc_clkgen u_clkgen (
        .clk_i    (REF_CLK_I),
        .rst_i    (RST_I),
        .run_i    (clk_run && (state_reg != ST_RESET)), // [RULE16]
        .ref_en_i (inh_level),
        .tick_o   (tick),
        .ref_o    (REF_OUT_O)
    );

    assign clk_run      = (state_reg != ST_BACKUP); // [RULE9]
    assign standby_done = tick && (cnt_reg == CNT_W'(STANDBY_TICKS - 1));

    // Operating state sequence
    always_comb begin
        state_next      = state_reg;
        cnt_next        = cnt_reg;
        from_reset_next = from_reset_reg;
        next_addr_next  = 1'b0;
        addr_zero_next  = 1'b0;
        case (state_reg)
            ST_RESET: begin
                cnt_next        = CNT_ZERO; // [RULE16]
                from_reset_next = 1'b1;
                if (!rst_pin_low) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (standby_done) begin
                    state_next = ST_RUN;
                    if (from_reset_reg) begin
                        addr_zero_next = 1'b1; // [RULE5]
                    end else begin
                        next_addr_next = 1'b1; // [RULE12]
                    end
                end else if (tick) begin
                    cnt_next = cnt_reg + 1'b1; // [RULE16]
                end
            end
            ST_RUN: begin
                if (WAIT_OP_I) begin
                    if (release_any) begin
                        next_addr_next = 1'b1; // [RULE3]
                    end else begin
                        state_next = ST_WAIT; // [RULE1]
                    end
                end else if (CLOCK_STOP_OP_I) begin
                    if (inh_level) begin
                        next_addr_next = 1'b1; // [RULE13]
                    end else begin
                        state_next = ST_BACKUP; // [RULE9]
                    end
                end
            end
            ST_WAIT: begin
                if (release_any) begin
                    state_next     = ST_RUN; // [RULE2]
                    next_addr_next = 1'b1;
                end
            end
            ST_BACKUP: begin
                cnt_next        = CNT_ZERO; // [RULE16]
                from_reset_next = 1'b0;
                if (inh_level) begin
                    state_next = ST_STANDBY; // [RULE12]
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
        if (rst_pin_low) begin
            state_next     = ST_RESET; // [RULE4]
            next_addr_next = 1'b0;
            addr_zero_next = 1'b0;
        end
    end

    // State registers; power-on reset enters system reset
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg      <= ST_RESET; // [RULE4]
            cnt_reg        <= CNT_ZERO;
            from_reset_reg <= 1'b1;
            next_addr_reg  <= 1'b0;
            addr_zero_reg  <= 1'b0;
        end else begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            from_reset_reg <= from_reset_next;
            next_addr_reg  <= next_addr_next;
            addr_zero_reg  <= addr_zero_next;
        end
    end

    // Port direction, output latch and pin drive
    always_comb begin
        dir_next       = dir_reg;
        out_latch_next = out_latch_reg;
        if (state_reg == ST_RESET) begin
            dir_next = DIR_INPUT; // [RULE7]
        end else if (DIR_WR_I && state_reg == ST_RUN) begin
            dir_next = DIR_DATA_I;
        end
        // Latch is never cleared by reset and frozen in backup
        if (OUT_WR_I && state_reg == ST_RUN) begin
            out_latch_next = OUT_DATA_I; // [RULE8]
        end
        if (state_reg == ST_BACKUP) begin
            pins_next = OUT_LOW; // [RULE10]
        end else begin
            pins_next = out_latch_reg; // [RULE11]
        end
        if (state_reg == ST_RUN || state_reg == ST_WAIT) begin
            disp_next = DISP_I;
        end else begin
            disp_next = DISP_LOW; // [RULE6]
        end
    end

    // Output port latch holds across system reset
    always_ff @(posedge REF_CLK_I) begin
        out_latch_reg <= out_latch_next; // [RULE8]
    end

    // Driven pin and direction registers
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            dir_reg  <= DIR_INPUT; // [RULE7]
            pins_reg <= OUT_LOW;
            disp_reg <= DISP_LOW;
        end else begin
            dir_reg  <= dir_next;
            pins_reg <= pins_next;
            disp_reg <= disp_next;
        end
    end

    // Outputs toward the sequencer and the pins
    assign CPU_HOLD_O    = (state_reg != ST_RUN);
    assign NEXT_ADDR_O   = next_addr_reg;
    assign ADDR_ZERO_O   = addr_zero_reg;
    assign BACKUP_O      = (state_reg == ST_BACKUP);
    assign CLK_GEN_RUN_O = clk_run;
    assign CPU_TICK_O    = tick;
    assign OUT_PINS_O    = pins_reg;
    assign IO_DIR_O      = dir_reg;
    assign DISP_O        = disp_reg;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    sequence seq_standby_last;
        state_reg == ST_STANDBY && standby_done && !rst_pin_low;
    endsequence

    AST_WAIT_HOLDS: assert property ( // [RULE1]
        state_reg == ST_WAIT && !release_any && !rst_pin_low
        |=> state_reg == ST_WAIT && !NEXT_ADDR_O)
        else $error("Wait left without a release condition");
    AST_WAIT_RELEASE: assert property ( // [RULE2]
        state_reg == ST_WAIT && release_any && !rst_pin_low
        |=> NEXT_ADDR_O && state_reg == ST_RUN)
        else $error("Wait release did not advance");
    AST_WAIT_NOOP: assert property ( // [RULE3]
        state_reg == ST_RUN && WAIT_OP_I && release_any && !rst_pin_low
        |=> state_reg == ST_RUN && NEXT_ADDR_O)
        else $error("Wait with release present stalled");
    AST_PIN_RESET: assert property ( // [RULE4]
        rst_pin_low |=> state_reg == ST_RESET && !NEXT_ADDR_O)
        else $error("Reset pin low without system reset");
    AST_START_ZERO: assert property ( // [RULE5]
        seq_standby_last ##0 from_reset_reg |=> ADDR_ZERO_O && !CPU_HOLD_O)
        else $error("Stand-by after reset did not start at zero");
    AST_DISP_LOW: assert property ( // [RULE6]
        state_reg == ST_RESET || state_reg == ST_STANDBY
        |=> DISP_O == DISP_LOW)
        else $error("Display driven during reset or stand-by");
    AST_DIR_INPUT: assert property ( // [RULE7]
        state_reg == ST_RESET |=> IO_DIR_O == DIR_INPUT)
        else $error("Ports not in input mode after reset");
    AST_BACKUP_ENTER: assert property ( // [RULE9]
        state_reg == ST_RUN && !WAIT_OP_I && CLOCK_STOP_OP_I
        && !inh_level && !rst_pin_low
        |=> BACKUP_O && !CLK_GEN_RUN_O)
        else $error("Clock stop with sense low did not enter backup");
    AST_BACKUP_PINS: assert property ( // [RULE10]
        BACKUP_O ##1 BACKUP_O |-> OUT_PINS_O == OUT_LOW)
        else $error("Output pins not low in backup");
    AST_LATCH_KEPT: assert property ( // [RULE11]
        BACKUP_O |=> $stable(out_latch_reg))
        else $error("Output latch changed in backup");
    AST_BACKUP_EXIT: assert property ( // [RULE12]
        BACKUP_O && inh_level && !rst_pin_low
        |=> state_reg == ST_STANDBY && cnt_reg == CNT_ZERO
        && !from_reset_reg)
        else $error("Backup exit did not start stand-by");
    AST_CLOCK_STOP_OP_NOOP: assert property ( // [RULE13]
        state_reg == ST_RUN && !WAIT_OP_I && CLOCK_STOP_OP_I
        && inh_level && !rst_pin_low
        |=> !BACKUP_O && NEXT_ADDR_O)
        else $error("Clock stop with sense high entered backup");

endmodule

// *** rwbc_seq_model.sv ***
// Stand-in for the CPU instruction sequencer: sends wait and clock-stop
// strobes and follows the program address from the step pulses.
// Assumes requests from the bench change at the falling clock edge.
`timescale 1ns/100ps
module rwbc_seq_model (
    input  wire logic clk_i,
    input  wire logic req_wait_i,
    input  wire logic req_stop_i,
    input  wire logic hold_i,
    input  wire logic next_i,
    input  wire logic zero_i,
    output logic      wait_op_o,
    output logic      stop_op_o,
    output int        pc_o
);
    // Start idle at address zero
    initial begin
        wait_op_o = 1'b0;
        stop_op_o = 1'b0;
        pc_o      = 0;
    end

    // One-cycle strobes, never while the address is held
    always @(negedge clk_i) begin
        wait_op_o <= req_wait_i & ~hold_i & ~wait_op_o;
        stop_op_o <= req_stop_i & ~hold_i & ~stop_op_o;
    end

    // Address restarts at zero or steps on a next-address pulse
    always @(posedge clk_i) begin
        if (zero_i === 1'b1) begin
            pc_o <= 0;
        end else if (next_i === 1'b1) begin
            pc_o <= pc_o + 1;
        end
    end
endmodule

// *** test_reset_wait_backup_control.sv ***
// Self-checking bench for the reset, wait and backup controller.
// Assumes the sequencer model beside it and a short stand-by count.
`timescale 1ns/100ps
module test_reset_wait_backup_control;
    import rwbc_pkg::*;
    localparam int SB = 5;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             rst_n = 1'b1;
    logic             sense = 1'b1;
    logic [KEY_W-1:0] key = '0;
    logic             flag = 1'b0;
    logic             req_w = 1'b0;
    logic             req_s = 1'b0;
    logic             out_wr = 1'b0;
    logic [OUT_W-1:0] out_d = '0;
    logic             dir_wr = 1'b0;
    logic [IO_W-1:0]  dir_d = '0;
    rwbc_disp_s       disp_in;
    logic             hold, nxt, zero, bk, gen, tick, refo, wop, sop;
    logic [OUT_W-1:0] outp;
    logic [IO_W-1:0]  iodir;
    rwbc_disp_s       disp_out;
    logic [OUT_W-1:0] exp_out;
    int               pc, exp_pc, miscompares, n_compared, seed, c, i;

    rwbc_ctrl #(.STANDBY_TICKS(SB)) i_dut (
        .REF_CLK_I(clk), .RST_I(rst), .RESET_N_PIN_I(rst_n),
        .BACKUP_SENSE_PIN_I(sense), .KEY_INPUT_LINES_I(key),
        .HALF_SECOND_TICK_FLAG_I(flag), .WAIT_OP_I(wop),
        .CLOCK_STOP_OP_I(sop), .OUT_WR_I(out_wr), .OUT_DATA_I(out_d),
        .DIR_WR_I(dir_wr), .DIR_DATA_I(dir_d), .DISP_I(disp_in),
        .CPU_HOLD_O(hold), .NEXT_ADDR_O(nxt), .ADDR_ZERO_O(zero),
        .BACKUP_O(bk), .CLK_GEN_RUN_O(gen), .CPU_TICK_O(tick),
        .REF_OUT_O(refo), .OUT_PINS_O(outp), .IO_DIR_O(iodir),
        .DISP_O(disp_out));

    rwbc_seq_model i_seq (
        .clk_i(clk), .req_wait_i(req_w), .req_stop_i(req_s),
        .hold_i(hold), .next_i(nxt), .zero_i(zero),
        .wait_op_o(wop), .stop_op_o(sop), .pc_o(pc));

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    // Compare one result and count it
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // Wait for a next-address or address-zero pulse, bounded
    task automatic wait_step(input bit z, output int n);
        n = 0;
        while (((z ? zero : nxt) !== 1'b1) && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask

    // Ask the sequencer for one wait or clock-stop strobe
    task automatic issue(input bit stp);
        if (stp) req_s <= 1'b1;
        else req_w <= 1'b1;
        @(negedge clk);
        req_s <= 1'b0;
        req_w <= 1'b0;
    endtask

    // Address model steps and is compared one edge after the pulse
    task automatic step_pc;
        cyc(1);
        exp_pc++;
        chk("pc", 32'(exp_pc), 32'(pc));
    endtask

    // Stand-by after any reset, ending at address zero
    task automatic boot;
        cyc(200);
        chk("disp standby", 32'h0, 32'(disp_out));
        chk("dir standby", 32'h0, 32'(iodir));
        wait_step(1'b1, c);
        c = c + 200;
        chk("standby len", 32'h1, 32'(c >= SB * TICK_CYC
            && c <= (SB + 1) * TICK_CYC + 10));
        cyc(1);
        exp_pc = 0;
        chk("pc zero", 32'(exp_pc), 32'(pc));
    endtask

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        results();
    end

    // Main sequence
    initial begin
        seed = 32'h467c;
        disp_in = (COM_W + SEG_W)'($random(seed));
        cyc(8);
        chk("disp reset", 32'h0, 32'(disp_out));
        rst <= 1'b0;
        boot();
        $display("test power-on done");
        out_d <= OUT_W'($random(seed));
        dir_d <= IO_W'($random(seed));
        out_wr <= 1'b1;
        dir_wr <= 1'b1;
        cyc(1);
        out_wr <= 1'b0;
        dir_wr <= 1'b0;
        exp_out = out_d;
        cyc(2);
        chk("out pins", 32'(exp_out), 32'(outp));
        chk("dir", 32'(dir_d), 32'(iodir));
        chk("disp run", 32'(disp_in), 32'(disp_out));
        c = 0;
        // Start counting in the first cycle after a tick
        @(posedge tick);
        cyc(2);
        while (tick !== 1'b1 && c < 500) begin
            @(negedge clk);
            c++;
        end
        chk("tick gap", 32'(TICK_CYC - 1), 32'(c));
        $display("test run done");
        // Wait released by key, sense change and half-second flag
        for (i = 0; i < 3; i++) begin
            issue(1'b0);
            cyc(1);
            chk("hold", 32'h1, 32'(hold));
            cyc(20);
            chk("held pc", 32'(exp_pc), 32'(pc));
            if (i == 0) key <= KEY_W'($random(seed)) | 4'h1;
            if (i == 1) sense <= 1'b0;
            if (i == 2) flag <= 1'b1;
            wait_step(1'b0, c);
            chk("release", 32'h1, 32'(c <= 6));
            step_pc();
            chk("hold off", 32'h0, 32'(hold));
            key <= '0;
            flag <= 1'b0;
            sense <= 1'b1;
            cyc(6);
        end
        $display("test wait done");
        // Wait with a release already present, then clock stop with sense high
        for (i = 0; i < 2; i++) begin
            if (i == 0) key <= 4'h8;
            else flag <= 1'b1;
            cyc(6);
            issue(1'b0);
            wait_step(1'b0, c);
            chk("noop wait", 32'h1, 32'(c));
            step_pc();
            key <= '0;
            flag <= 1'b0;
            cyc(6);
        end
        issue(1'b1);
        wait_step(1'b0, c);
        chk("noop stop", 32'h1, 32'(c));
        chk("no backup", 32'h0, 32'(bk));
        step_pc();
        $display("test no-op done");
        // Backup entry and exit
        sense <= 1'b0;
        cyc(6);
        issue(1'b1);
        cyc(3);
        chk("backup", 32'h1, 32'(bk));
        chk("gen stop", 32'h0, 32'(gen));
        chk("out low", 32'h0, 32'(outp));
        chk("disp low", 32'h0, 32'(disp_out));
        c = 0;
        repeat (300) begin
            @(negedge clk);
            if (tick !== 1'b0 || refo !== 1'b0) c++;
        end
        chk("quiet", 32'h0, 32'(c));
        chk("stop pc", 32'(exp_pc), 32'(pc));
        sense <= 1'b1;
        wait_step(1'b0, c);
        chk("exit len", 32'h1, 32'(c >= SB * TICK_CYC
            && c <= (SB + 1) * TICK_CYC + 10));
        step_pc();
        chk("out kept", 32'(exp_out), 32'(outp));
        $display("test backup done");
        // Reset pin
        rst_n <= 1'b0;
        cyc(6);
        chk("pin reset", 32'h1, 32'(hold));
        chk("disp pin", 32'h0, 32'(disp_out));
        rst_n <= 1'b1;
        boot();
        cyc(2);
        chk("out intact", 32'(exp_out), 32'(outp));
        chk("dir input", 32'h0, 32'(iodir));
        $display("test reset pin done");
        results();
    end
endmodule
